/* pkg/tit_defs.vh */
// Constants for the triple interval timer: offsets, control fields, modes.
// Assumes inclusion by bare name from the design files.
`ifndef TIT_DEFS_VH
`define TIT_DEFS_VH
`define TIT_ADDR_W        5
`define TIT_OFF_CNT0      5'h14
`define TIT_OFF_CNT1      5'h15
`define TIT_OFF_CNT2      5'h16
`define TIT_OFF_CTRL      5'h17
`define TIT_SEL_HI        7
`define TIT_SEL_LO        6
`define TIT_ACC_HI        5
`define TIT_ACC_LO        4
`define TIT_MODE_HI       3
`define TIT_MODE_LO       1
`define TIT_BCD_BIT       0
`define TIT_RB_CNT_N      5
`define TIT_RB_STA_N      4
`define TIT_SEL_RB        2'h3
`define TIT_ACC_LATCH     2'h0
`define TIT_ACC_LSB       2'h1
`define TIT_ACC_MSB       2'h2
`define TIT_ACC_WORD      2'h3
`define TIT_CTRL_RST      6'h00
`define TIT_CNT_RST       16'h0000
`define TIT_CLK_HZ        100000000
`define TIT_CNT_HZ        10000000
`define TIT_DIV           (`TIT_CLK_HZ / `TIT_CNT_HZ)
`define TIT_DIV_LAST      4'h9
`endif

/* hw/tit_sync.v */
// Three-stage input synchroniser with agreement filter for a pin level.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/1ns
module tit_sync (
    clk,
    rst,
    din,
    dout
);
    input  wire clk;
    input  wire rst;
    input  wire din;
    output reg  dout;
    reg         s1_q;
    reg         s2_q;
    reg         s3_q;
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule

/* hw/tit_counter.v */
// One 16-bit down counter with six modes, binary or decimal counting.
// Assumes a one-cycle count enable tick and a synchronised gate level.
`timescale 1ns/1ns
`include "tit_defs.vh"
module tit_counter (
    clk,
    rst,
    tick,
    gate,
    cfg_wr,
    cfg_mode,
    cfg_bcd,
    load,
    load_val,
    count,
    out,
    null_cnt
);
    input  wire        clk;
    input  wire        rst;
    input  wire        tick;
    input  wire        gate;
    input  wire        cfg_wr;
    input  wire [2:0]  cfg_mode;
    input  wire        cfg_bcd;
    input  wire        load;
    input  wire [15:0] load_val;
    output wire [15:0] count;
    output wire        out;
    output wire        null_cnt;

    reg  [15:0] ce_q;
    reg  [15:0] cr_q;
    reg         out_q;
    reg         nc_q;
    reg         arm_q;
    reg         trig_q;
    reg         gate_q;
    reg         run_q;
    wire [1:0]  m_lo = cfg_mode[1:0];
    wire        periodic = cfg_mode[1];
    wire        rise = gate & ~gate_q;

    // Decrement by one or two with decimal digit borrow
    function [15:0] dec_by;
        input [15:0] v;
        input        bcd;
        input [1:0]  step;
        reg   [15:0] r;
        integer      i;
        begin
            r = v;
            for (i = 0; i < 2; i = i + 1) begin
                if (i < step) begin
                    if (!bcd) begin
                        r = r - 16'h0001;
                    end else if (r[3:0] != 4'h0) begin
                        r[3:0] = r[3:0] - 4'h1;
                    end else if (r[7:4] != 4'h0) begin
                        r[7:0] = {r[7:4] - 4'h1, 4'h9};
                    end else if (r[11:8] != 4'h0) begin
                        r[11:0] = {r[11:8] - 4'h1, 8'h99};
                    end else if (r[15:12] != 4'h0) begin
                        r = {r[15:12] - 4'h1, 12'h999};
                    end else begin
                        r = 16'h9999;
                    end
                end
            end
            dec_by = r;
        end
    endfunction

    wire [15:0] ce_m1 = dec_by(ce_q, cfg_bcd, 2'd1);
    wire [15:0] ce_m2 = dec_by(ce_q, cfg_bcd, 2'd2);
    wire [15:0] sq_ld = {cr_q[15:1], 1'b0};

    assign count    = ce_q;
    assign out      = out_q;
    assign null_cnt = nc_q;

    always @(posedge clk) begin
        if (rst) begin
            ce_q   <= `TIT_CNT_RST;
            cr_q   <= `TIT_CNT_RST;
            out_q  <= 1'b1;
            nc_q   <= 1'b0;
            arm_q  <= 1'b0;
            trig_q <= 1'b0;
            gate_q <= 1'b0;
            run_q  <= 1'b0;
        end else begin
            gate_q <= gate;
            if (rise) begin
                trig_q <= 1'b1;
            end
            if (cfg_wr) begin
                out_q <= (cfg_mode == 3'd0) ? 1'b0 : 1'b1;
                run_q <= 1'b0;
                arm_q <= 1'b0;
            end else if (load) begin
                cr_q <= load_val;
                nc_q <= 1'b1;
                arm_q <= 1'b1;
                if (cfg_mode == 3'd0) begin
                    out_q <= 1'b0;
                end
            end else if (tick) begin
                trig_q <= rise;
                if (!periodic && cfg_mode[0]) begin
                    // Modes 1 and 5 load only on a trigger
                    if (trig_q) begin
                        ce_q  <= cr_q;
                        nc_q  <= 1'b0;
                        run_q <= 1'b1;
                        if (cfg_mode[2] == 1'b0) begin
                            out_q <= 1'b0;
                        end else begin
                            out_q <= 1'b1;
                        end
                    end else if (run_q) begin
                        ce_q <= ce_m1;
                        if (ce_q == 16'h0001) begin
                            run_q <= 1'b0;
                            out_q <= cfg_mode[2] ? 1'b0 : 1'b1;
                        end else begin
                            // Mode 1 holds low while running, mode 5 high
                            out_q <= cfg_mode[2];
                        end
                    end else begin
                        out_q <= 1'b1;
                        ce_q  <= ce_m1;
                    end
                end else if (arm_q || (periodic && rise)) begin
                    ce_q  <= (m_lo == 2'b11) ? sq_ld : cr_q;
                    nc_q  <= 1'b0;
                    arm_q <= 1'b0;
                    run_q <= 1'b1;
                    out_q <= (cfg_mode != 3'h0);
                end else if (periodic) begin
                    if (gate) begin
                        if (m_lo == 2'b10) begin
                            // Divide by N with one low clock
                            if (ce_q == 16'h0002) begin
                                out_q <= 1'b0;
                                ce_q  <= ce_m1;
                            end else if (ce_q == 16'h0001) begin
                                out_q <= 1'b1;
                                ce_q  <= cr_q;
                            end else begin
                                ce_q <= ce_m1;
                            end
                        end else begin
                            // Odd count: extra count spent in high half
                            if (cr_q[0] && out_q && ce_q == sq_ld) begin
                                ce_q <= ce_m1;
                            end else if (ce_q == 16'h0002 ||
                                (ce_q == 16'h0001 && cr_q[0] && out_q)) begin
                                out_q <= ~out_q;
                                ce_q  <= sq_ld;
                            end else begin
                                ce_q <= ce_m2;
                            end
                        end
                    end else begin
                        out_q <= 1'b1;
                    end
                end else if (gate) begin
                    // Modes 0 and 4 count while the gate is high
                    ce_q <= ce_m1;
                    if (cfg_mode[2]) begin
                        out_q <= !(run_q && ce_q == 16'h0001);
                        if (ce_q == 16'h0001) begin
                            run_q <= 1'b0;
                        end
                    end else if (ce_q == 16'h0001) begin
                        out_q <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

/* hw/tit_top.v */
// Triple interval timer: three down counters, control byte, latch logic.
// Assumes a byte register port and gate levels from a board gate register.
`timescale 1ns/1ns
`include "tit_defs.vh"
module tit_top (
    clk,
    rst,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    gate_pin,
    out0,
    out2
);
    input  wire                   clk;
    input  wire                   rst;
    input  wire [`TIT_ADDR_W-1:0] addr;
    input  wire [7:0]             wdata;
    input  wire                   wr;
    input  wire                   rd;
    output reg  [7:0]             rdata;
    input  wire [2:0]             gate_pin;
    output reg                    out0;
    output reg                    out2;

    reg  [3:0]  div_q;
    reg         tick_q;
    reg  [5:0]  cfg_q   [0:2];
    reg  [7:0]  lsb_q   [0:2];
    reg  [15:0] hold_q  [0:2];
    reg  [7:0]  stat_q  [0:2];
    reg  [2:0]  hlat_q;
    reg  [2:0]  slat_q;
    reg  [2:0]  rtog_q;
    reg  [2:0]  wtog_q;
    reg  [2:0]  cfg_wr_q;
    reg  [2:0]  ld_q;
    reg  [15:0] ldv_q   [0:2];
    reg         out1_q;
    wire [2:0]  gate_s;
    wire [15:0] cnt     [0:2];
    wire [2:0]  outs;
    wire [2:0]  ncs;
    wire [2:0]  ticks;

    // Address decode used by both read and write paths
    function [2:0] ctr_hit;
        input [`TIT_ADDR_W-1:0] a;
        begin
            ctr_hit = 3'b000;
            if (a == `TIT_OFF_CNT0) ctr_hit = 3'b001;
            if (a == `TIT_OFF_CNT1) ctr_hit = 3'b010;
            if (a == `TIT_OFF_CNT2) ctr_hit = 3'b100;
        end
    endfunction

    wire [2:0] whit = wr ? ctr_hit(addr) : 3'b000;
    wire [2:0] rhit = rd ? ctr_hit(addr) : 3'b000;
    wire       cwr  = wr && (addr == `TIT_OFF_CTRL);
    wire [1:0] sel  = wdata[`TIT_SEL_HI:`TIT_SEL_LO];
    wire [1:0] acc  = wdata[`TIT_ACC_HI:`TIT_ACC_LO];
    wire       rb   = cwr && (sel == `TIT_SEL_RB);

    // Ten-to-one divider gives the 10MHz counting rate
    always @(posedge clk) begin
        if (rst) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == `TIT_DIV_LAST);
            div_q  <= (div_q == `TIT_DIV_LAST) ? 4'h0 : div_q + 4'h1;
        end
    end

    // Third counter only steps when the second wraps its output low
    assign ticks[0] = tick_q;
    assign ticks[1] = tick_q;
    assign ticks[2] = tick_q && out1_q && !outs[1];

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : ctr
            tit_sync u_sync (
                .clk  (clk),
                .rst  (rst),
                .din  (gate_pin[g]),
                .dout (gate_s[g])
            );
            tit_counter u_ctr (
                .clk      (clk),
                .rst      (rst),
                .tick     (ticks[g]),
                .gate     (gate_s[g]),
                .cfg_wr   (cfg_wr_q[g]),
                .cfg_mode (cfg_q[g][3:1]),
                .cfg_bcd  (cfg_q[g][0]),
                .load     (ld_q[g]),
                .load_val (ldv_q[g]),
                .count    (cnt[g]),
                .out      (outs[g]),
                .null_cnt (ncs[g])
            );
        end
    endgenerate

    integer k;
    always @(posedge clk) begin
        if (rst) begin
            for (k = 0; k < 3; k = k + 1) begin
                cfg_q[k]  <= `TIT_CTRL_RST;
                lsb_q[k]  <= 8'h00;
                hold_q[k] <= `TIT_CNT_RST;
                stat_q[k] <= 8'h00;
                ldv_q[k]  <= `TIT_CNT_RST;
            end
            hlat_q   <= 3'b000;
            slat_q   <= 3'b000;
            rtog_q   <= 3'b000;
            wtog_q   <= 3'b000;
            cfg_wr_q <= 3'b000;
            ld_q     <= 3'b000;
            rdata    <= 8'h00;
            out0     <= 1'b1;
            out2     <= 1'b1;
            out1_q   <= 1'b1;
        end else begin
            out0     <= outs[0];
            out2     <= outs[2];
            // Sampled on ticks only, so the fall is still seen at next step
            if (tick_q) begin
                out1_q <= outs[1];
            end
            cfg_wr_q <= 3'b000;
            ld_q     <= 3'b000;
            rdata    <= 8'h00;
            for (k = 0; k < 3; k = k + 1) begin
                // Control byte for one counter
                if (cwr && !rb && sel == k[1:0]) begin
                    if (acc == `TIT_ACC_LATCH) begin
                        if (!hlat_q[k]) begin
                            hold_q[k] <= cnt[k];
                            hlat_q[k] <= 1'b1;
                        end
                    end else begin
                        // Mode code kept whole; counter treats 6 and 7 as modes 2 and 3
                        cfg_q[k]    <= wdata[5:0];
                        cfg_wr_q[k] <= 1'b1;
                        rtog_q[k]   <= 1'b0;
                        wtog_q[k]   <= 1'b0;
                        hlat_q[k]   <= 1'b0;
                        slat_q[k]   <= 1'b0;
                    end
                end
                // Readback latches all picked counters at once
                if (rb && wdata[k+1]) begin
                    if (!wdata[`TIT_RB_CNT_N] && !hlat_q[k]) begin
                        hold_q[k] <= cnt[k];
                        hlat_q[k] <= 1'b1;
                    end
                    if (!wdata[`TIT_RB_STA_N] && !slat_q[k]) begin
                        stat_q[k] <= {outs[k], ncs[k], cfg_q[k]};
                        slat_q[k] <= 1'b1;
                    end
                end
                // Count writes
                if (whit[k]) begin
                    case (cfg_q[k][5:4])
                        `TIT_ACC_LSB: begin
                            ldv_q[k] <= {8'h00, wdata};
                            ld_q[k]  <= 1'b1;
                        end
                        `TIT_ACC_MSB: begin
                            ldv_q[k] <= {wdata, 8'h00};
                            ld_q[k]  <= 1'b1;
                        end
                        `TIT_ACC_WORD: begin
                            if (!wtog_q[k]) begin
                                lsb_q[k] <= wdata;
                            end else begin
                                ldv_q[k] <= {wdata, lsb_q[k]};
                                ld_q[k]  <= 1'b1;
                            end
                            wtog_q[k] <= ~wtog_q[k];
                        end
                        default: begin
                            ld_q[k] <= 1'b0;
                        end
                    endcase
                end
                // Reads: status first, then held or live count
                if (rhit[k]) begin
                    if (slat_q[k]) begin
                        rdata     <= stat_q[k];
                        slat_q[k] <= 1'b0;
                    end else begin
                        case (cfg_q[k][5:4])
                            `TIT_ACC_MSB: begin
                                rdata <= hlat_q[k] ? hold_q[k][15:8]
                                                   : cnt[k][15:8];
                                hlat_q[k] <= 1'b0;
                            end
                            `TIT_ACC_WORD: begin
                                if (!rtog_q[k]) begin
                                    rdata <= hlat_q[k] ? hold_q[k][7:0]
                                                       : cnt[k][7:0];
                                end else begin
                                    rdata <= hlat_q[k] ? hold_q[k][15:8]
                                                       : cnt[k][15:8];
                                    hlat_q[k] <= 1'b0;
                                end
                                rtog_q[k] <= ~rtog_q[k];
                            end
                            default: begin
                                rdata <= hlat_q[k] ? hold_q[k][7:0]
                                                   : cnt[k][7:0];
                                hlat_q[k] <= 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end
endmodule

/* tb/tit_top_chk.sv */
// Assertion checker for the timer top: bus answers and counter 0 output.
// Assumes binding to the timer top; sees only its ports.
`timescale 1ns/1ns
`include "tit_defs.vh"
module tit_chk (
    input logic                   clk,
    input logic                   rst,
    input logic [`TIT_ADDR_W-1:0] addr,
    input logic [7:0]             wdata,
    input logic                   wr,
    input logic                   rd,
    input logic [7:0]             rdata,
    input logic [2:0]             gate_pin,
    input logic                   out0,
    input logic                   out2
);
    logic [2:0] mode0_q;
    logic [1:0] acc0_q;
    logic       tog0_q;
    logic       ctl0;
    logic       load0;
    logic       m2;
    logic [1:0] cage_q;
    logic [4:0] glo_q;
    assign ctl0  = wr && addr == `TIT_OFF_CTRL && wdata[7:6] == 2'h0
                   && wdata[5:4] != `TIT_ACC_LATCH;
    // Word mode loads only on the second byte, so track the toggle
    assign load0 = wr && addr == `TIT_OFF_CNT0 && acc0_q != `TIT_ACC_LATCH
                   && (acc0_q != `TIT_ACC_WORD || tog0_q);
    // A mode switch may cut a pulse short, so skip a few cycles after it
    assign m2    = mode0_q[1:0] == 2'h2 && cage_q == 2'h3;
    always_ff @(posedge clk) begin
        if (rst || ctl0) begin
            cage_q <= 2'h0;
        end else if (cage_q != 2'h3) begin
            cage_q <= cage_q + 2'h1;
        end
        if (rst || ctl0 || !mode0_q[1] || gate_pin[0]) begin
            glo_q <= 5'h00;
        end else if (glo_q != 5'h1F) begin
            glo_q <= glo_q + 5'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            mode0_q <= 3'h0;
            acc0_q  <= 2'h0;
            tog0_q  <= 1'b0;
        end else if (ctl0) begin
            mode0_q <= wdata[3:1];
            acc0_q  <= wdata[5:4];
            tog0_q  <= 1'b0;
        end else if (wr && addr == `TIT_OFF_CNT0) begin
            tog0_q  <= ~tog0_q;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property (
        !$past(rd) |-> rdata == 8'h00) else $error("rdata without read");
    chk_ctrl_rd: assert property (
        rd && addr == `TIT_OFF_CTRL |=> rdata == 8'h00)
        else $error("control location read back");
    chk_unmapped_rd: assert property (
        rd && (addr < `TIT_OFF_CNT0 || addr > `TIT_OFF_CTRL)
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    chk_m0_load_low: assert property (
        load0 && mode0_q == 3'h0 |-> ##[1:12] !out0)
        else $error("mode 0 load left output high");
    chk_m2_pulse: assert property (
        $fell(out0) && m2 && gate_pin[0] |-> ##9 !out0 ##1 out0)
        else $error("mode 2 low pulse not one tick");
    chk_m23_gate_hi: assert property (
        glo_q >= 5'h14 |-> out0)
        else $error("low gate did not hold output high");
    chk_m0_gate_hold: assert property (
        (mode0_q == 3'h0 && !gate_pin[0] && !wr)[*8] |-> !$rose(out0))
        else $error("mode 0 counted with gate low");
    chk_m4_gate_hold: assert property (
        (mode0_q == 3'h4 && !gate_pin[0] && !wr)[*8] |-> !$fell(out0))
        else $error("mode 4 counted with gate low");
    cov_m0_load: cover property (load0 && mode0_q == 3'h0);
    cov_m2_pulse: cover property ($fell(out0) && m2);
    cov_cascade: cover property ($fell(out2));
endmodule

bind tit_top tit_chk tit_chk_inst (
    .clk      (clk),
    .rst      (rst),
    .addr     (addr),
    .wdata    (wdata),
    .wr       (wr),
    .rd       (rd),
    .rdata    (rdata),
    .gate_pin (gate_pin),
    .out0     (out0),
    .out2     (out2)
);

/* tb/tit_host.sv */
// Host model: drives the byte register port and the board gate levels.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/1ns
`include "tit_defs.vh"
module tit_host (
    input  logic                   clk,
    output logic [`TIT_ADDR_W-1:0] addr,
    output logic [7:0]             wdata,
    output logic                   wr,
    output logic                   rd,
    output logic [2:0]             gate_pin
);
    logic [7:0] exp_q[$];
    initial begin
        addr     = 5'h00;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        gate_pin = 3'h0;
    end
    // Released lines show the inverse so stale values cannot pass
    task automatic wb(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask
    task automatic rb(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
    endtask
    // Word access always comes as a whole pair, low byte first
    task automatic wp(input logic [4:0] a, input logic [15:0] v);
        wb(a, v[7:0]);
        wb(a, v[15:8]);
    endtask
    task automatic rp(input logic [4:0] a, input logic [15:0] e);
        rb(a, e[7:0]);
        rb(a, e[15:8]);
    endtask
    task automatic gt(input logic [2:0] g);
        @(posedge clk);
        gate_pin <= g;
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the triple interval timer.
// Assumes the host model drives the port; reads are checked from a queue.
`timescale 1ns/1ns
`include "tit_defs.vh"
module tb_top;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic [`TIT_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic [7:0]             rdata;
    logic                   wr;
    logic                   rd;
    logic                   rd_d = 1'b0;
    logic [2:0]             gate_pin;
    logic                   out0;
    logic                   out2;
    int                     err_total = 0;
    int                     n_compared = 0;
    int                     seed = 3925;
    logic [7:0] pc [5] = '{8'h14, 8'h1C, 8'h16, 8'h1E, 8'h15};
    logic [7:0] pn [5] = '{8'h04, 8'h04, 8'h05, 8'h06, 8'h10};
    int         plo [5] = '{10, 10, 20, 30, 10};
    int         phi [5] = '{30, 30, 30, 30, 90};
    logic [7:0] oc [3] = '{8'h12, 8'h18, 8'h1A};
    int         olo [3] = '{30, 10, 10};
    logic [7:0] ac [2] = '{8'h10, 8'h20};
    always #5 clk = ~clk;
    tit_top tit_top_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .gate_pin(gate_pin), .out0(out0),
        .out2(out2)
    );
    tit_host tit_host_inst (
        .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .gate_pin(gate_pin)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic o(input int s);
        return s ? out2 : out0;
    endfunction
    // Bounded so a stuck output shows up as a wrong width, not a hang
    task automatic wt(input int s, input logic l, output int k);
        k = 0;
        while (o(s) === l && k < 3000) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic meas(input int s, input int lo, input int hi);
        int k;
        wt(s, 1'b0, k);
        wt(s, 1'b1, k);
        wt(s, 1'b0, k);
        chk(16'(k), 16'(lo));
        if (hi > 0) begin
            wt(s, 1'b1, k);
            chk(16'(k), 16'(hi));
        end
        repeat (20) @(negedge clk);
    endtask
    always @(posedge clk) begin
        rd_d <= rd & ~rst;
        if (rd_d)
            chk(16'(rdata), 16'(tit_host_inst.exp_q.pop_front()));
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [15:0] v;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        v = 16'($random(seed));
        tit_host_inst.rb(5'h17, 8'h00);
        tit_host_inst.rb({1'b0, 4'($random(seed))}, 8'h00);
        tit_host_inst.wb(5'h17, 8'h30);
        tit_host_inst.wp(5'h14, v);
        repeat (40) @(posedge clk);
        tit_host_inst.wb(5'h17, 8'hC2);
        tit_host_inst.rb(5'h14, 8'h30);
        tit_host_inst.rp(5'h14, v);
        tit_host_inst.wb(5'h17, 8'h00);
        tit_host_inst.wb(5'h17, 8'hE2);
        tit_host_inst.rb(5'h14, 8'h30);
        tit_host_inst.rp(5'h14, v);
        tit_host_inst.wb(5'h17, 8'h00);
        tit_host_inst.gt(3'h1);
        repeat (100) @(posedge clk);
        tit_host_inst.wb(5'h17, 8'h00);
        tit_host_inst.rp(5'h14, v);
        foreach (ac[i]) begin
            tit_host_inst.gt(3'h0);
            tit_host_inst.wb(5'h17, ac[i]);
            tit_host_inst.wb(5'h14, 8'hA5);
            tit_host_inst.wb(5'h17, 8'hE2);
            tit_host_inst.rb(5'h14, {2'b01, ac[i][5:0]});
            repeat (40) @(posedge clk);
            tit_host_inst.wb(5'h17, 8'h00);
            tit_host_inst.rb(5'h14, 8'hA5);
        end
        tit_host_inst.wb(5'h17, 8'h10);
        tit_host_inst.gt(3'h1);
        tit_host_inst.wb(5'h14, 8'h05);
        repeat (15) @(negedge clk);
        chk(16'(out0), 16'h0000);
        repeat (100) @(negedge clk);
        chk(16'(out0), 16'h0001);
        for (int i = 0; i < 5; i++) begin
            tit_host_inst.wb(5'h17, pc[i]);
            tit_host_inst.wb(5'h14, pn[i]);
            meas(0, plo[i], phi[i]);
        end
        tit_host_inst.gt({2'($random(seed)), 1'b0});
        repeat (30) @(negedge clk);
        chk(16'(out0), 16'h0001);
        tit_host_inst.gt(3'h7);
        tit_host_inst.wb(5'h17, 8'h54);
        tit_host_inst.wb(5'h15, 8'h02);
        tit_host_inst.wb(5'h17, 8'h96);
        tit_host_inst.wb(5'h16, 8'h02);
        meas(1, 20, 20);
        for (int i = 0; i < 3; i++) begin
            tit_host_inst.gt(3'h0);
            tit_host_inst.wb(5'h17, oc[i]);
            tit_host_inst.wb(5'h14, 8'h03);
            repeat (100) @(negedge clk);
            chk(16'(out0), 16'h0001);
            tit_host_inst.gt(3'h1);
            meas(0, olo[i], 0);
        end
        repeat (5) @(posedge clk);
        tally_and_finish();
    end
endmodule
